//--- rtl/wltm_pkg.sv
// Purpose: Shared constants for the word lane transfer mixer.
// Assumes: 100 MHz system clock, 36-bit buffers, 12- or 18-bit host bus.
// Notes: Pulse widths are kept in ns; cycle counts are derived here.
`default_nettype none
package wltm_pkg;
   // Clock period in ns
   localparam int CLK_PERIOD_NS = 10;
   // Read strobe widths in ns for the two host kinds
   localparam int SHORT_PULSE_NS = 100;
   localparam int LONG_PULSE_NS = 1000;
   // Strobe widths in cycles, never below one cycle
   localparam int SHORT_PULSE_CYC = (SHORT_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    SHORT_PULSE_NS / CLK_PERIOD_NS;
   localparam int LONG_PULSE_CYC = (LONG_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   LONG_PULSE_NS / CLK_PERIOD_NS;
   localparam int CNT_W = $clog2(LONG_PULSE_CYC + 1);
   // Buffer and bus widths
   localparam int WORD_W = 36;
   localparam int HOST_W = 18;
   localparam int SEL_W = 6;
   // Default selection codes, octal 70, 71, 72
   localparam logic [5:0] SEL_CODE0_DEF = 6'h38;
   localparam logic [5:0] SEL_CODE1_DEF = 6'h39;
   localparam logic [5:0] SEL_CODE2_DEF = 6'h3a;
   // Lane field boundaries inside the 36-bit word
   localparam int L0_LO = 0;
   localparam int L1_LO = 12;
   localparam int L2_LO = 18;
   localparam int L3_LO = 24;
   // Lane strobe bit indices
   localparam int LANE0 = 0;
   localparam int LANE1 = 1;
   localparam int LANE2 = 2;
   localparam int LANE3 = 3;
   // Lane masks for each transfer step
   localparam logic [3:0] M_FIRST12 = 4'h1;
   localparam logic [3:0] M_MID12 = 4'h6;
   localparam logic [3:0] M_LAST12 = 4'h8;
   localparam logic [3:0] M_FIRST18 = 4'h3;
   localparam logic [3:0] M_LAST18 = 4'hc;
   localparam logic [3:0] M_NONE = 4'h0;
   // Host kind
   typedef enum logic {WLTM_HOST12, WLTM_HOST18} wltm_host_e;
endpackage
`default_nettype wire

//--- rtl/wltm_stream_if.sv
// Purpose: Valid/ready word carrier between the mixer and its buffer.
// Assumes: Single clock domain.
// Notes: Source drives valid and data, sink drives ready.
`timescale 1ns/1ps
`default_nettype none
interface wltm_stream_if #(parameter int WIDTH = 36);
   logic valid; // Word offered
   logic ready; // Word accepted when valid
   logic [WIDTH-1:0] data; // Word content
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/wltm_skid_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Synchronous active-high reset.
// Notes: Full after two words; ready drops so the source stalls.
`timescale 1ns/1ps
`default_nettype none
module wltm_skid_buf #(
   parameter int WIDTH = 36
) (
   input wire logic clk,
   input wire logic sys_rst,
   wltm_stream_if.snk in_if,
   wltm_stream_if.src out_if
);
   import wltm_pkg::*;

   // Refuse a zero-width build
   if (WIDTH < 1) begin : g_chk
      $error("wltm_skid_buf: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] mem_r [2]; // Two storage slots
   logic rd_idx_r; // Slot read next
   logic wr_idx_r; // Slot written next
   logic [1:0] cnt_r; // Words held
   logic push; // Word entering
   logic pop; // Word leaving

   // Honest full and empty from the count
   assign in_if.ready = (cnt_r != 2'h2);
   assign out_if.valid = (cnt_r != 2'h0);
   assign out_if.data = mem_r[rd_idx_r];
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_idx_r] <= in_if.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_idx_r <= 1'b0;
         wr_idx_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            wr_idx_r <= ~wr_idx_r;
         end
         if (pop) begin
            rd_idx_r <= ~rd_idx_r;
         end
         // Simultaneous push and pop leaves the count alone
         if (push && !pop) begin
            cnt_r <= cnt_r + 2'h1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end
endmodule // wltm_skid_buf
`default_nettype wire

//--- rtl/wltm_mixer.sv
// Purpose: Lane sequencing between 36-bit buffers and a 12/18-bit host bus.
// Assumes: Host pulses are synchronous one-cycle strobes; configuration is static.
// Notes: Outbound words pass a two-entry buffer before the outbound buffer.
// Contract
// - Respond to three configured selection codes only.
// - Decode instruction bits 3 to 8.
// - Support 12-bit and 18-bit host modes.
// - Hold 18-bit read data about one microsecond.
// - Read strobes 100 ns or 1 us.
// - Three 12-bit reads; first gives bits 0-11.
// - Middle read enables lanes 12-17, 18-23 together.
// - Third 12-bit read gives bits 24-35.
// - Three 12-bit loads fill inbound lanes in order.
// - First 18-bit read also strobes lane 12-17.
// - Second 18-bit read gives bits 18-35.
// - Two 18-bit loads fill bits 0-17, 18-35.
// - Last lane read empties the outbound buffer.
// - Last lane load sets inbound full.
`timescale 1ns/1ps
`default_nettype none
module wltm_mixer (
   input wire logic clk,
   input wire logic sys_rst,
   // Static configuration
   input wire logic host18_mode,
   input wire logic [wltm_pkg::SEL_W-1:0] sel_code0,
   input wire logic [wltm_pkg::SEL_W-1:0] sel_code1,
   input wire logic [wltm_pkg::SEL_W-1:0] sel_code2,
   // Host I/O bus
   input wire logic [wltm_pkg::SEL_W-1:0] host_sel,
   input wire logic host_rd,
   input wire logic host_ld,
   input wire logic [wltm_pkg::HOST_W-1:0] host_wdata,
   output logic [wltm_pkg::HOST_W-1:0] host_rdata,
   output logic host_rdata_en,
   output logic [3:0] lane_rd_strobe,
   output logic [3:0] lane_ld_strobe,
   // Wide side, outbound words in
   input wire logic ob_valid,
   input wire logic [wltm_pkg::WORD_W-1:0] ob_data,
   output logic ob_ready,
   output logic ob_full,
   output logic ob_empty,
   // Wide side, inbound words out
   output logic ib_valid,
   output logic [wltm_pkg::WORD_W-1:0] ib_data,
   input wire logic ib_ready
);
   import wltm_pkg::*;

   // Match of a selection code against instruction bits 3 to 8
   function automatic logic sel_hit(input logic [SEL_W-1:0] sel, input logic [SEL_W-1:0] code);
      sel_hit = (sel == code);
   endfunction

   // Gather the masked lanes into host bus order for the given mode
   function automatic logic [HOST_W-1:0] lane_mux(input logic [WORD_W-1:0] w,
                                                  input logic [3:0] m, input logic h18);
      logic [HOST_W-1:0] r;
      r = '0;
      if (h18) begin
         if (m[LANE0]) r[11:0] = w[L1_LO-1:L0_LO];
         if (m[LANE1]) r[17:12] = w[L2_LO-1:L1_LO];
         if (m[LANE2]) r[5:0] = w[L3_LO-1:L2_LO];
         if (m[LANE3]) r[17:6] = w[WORD_W-1:L3_LO];
      end else begin
         if (m[LANE0]) r[11:0] = w[L1_LO-1:L0_LO];
         if (m[LANE1]) r[5:0] = w[L2_LO-1:L1_LO];
         if (m[LANE2]) r[11:6] = w[L3_LO-1:L2_LO];
         if (m[LANE3]) r[11:0] = w[WORD_W-1:L3_LO];
      end
      lane_mux = r;
   endfunction

   wltm_stream_if #(.WIDTH(WORD_W)) buf_in_if ();
   wltm_stream_if #(.WIDTH(WORD_W)) buf_out_if ();

   logic [WORD_W-1:0] outbound_buffer_r; // Word awaiting host reads
   logic ob_full_r; // Outbound word present
   logic [WORD_W-1:0] inbound_buffer_r; // Word assembled from host loads
   logic ib_full_r; // Inbound word complete
   logic [CNT_W-1:0] rd_cnt_r; // Remaining read strobe cycles
   logic [3:0] rd_mask_r; // Lanes strobed by current read
   logic [HOST_W-1:0] rdata_r; // Data held on host bus
   logic [3:0] ld_mask_r; // One-cycle load strobe copy
   logic [1:0] hit; // Index of matched code
   logic any_hit; // Some code matched
   logic [3:0] rd_mask_nxt; // Lanes for an accepted read
   logic [3:0] ld_mask_nxt; // Lanes for an accepted load
   logic rd_go; // Read accepted this cycle
   logic ld_go; // Load accepted this cycle
   logic rd_busy; // Strobe still running
   wltm_host_e host_kind; // Configured host kind

   assign host_kind = host18_mode ? WLTM_HOST18 : WLTM_HOST12;

   // Outbound words pass the two-entry buffer
   assign buf_in_if.valid = ob_valid;
   assign buf_in_if.data = ob_data;
   assign ob_ready = buf_in_if.ready;
   // Drain only when the outbound buffer is free, so a slow host stalls the source
   assign buf_out_if.ready = !ob_full_r;

   wltm_skid_buf #(.WIDTH(WORD_W)) u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_if(buf_in_if),
      .out_if(buf_out_if)
   );

   // Selection decode; anything else is ignored
   always_comb begin
      any_hit = 1'b1;
      if (sel_hit(host_sel, sel_code0)) begin
         hit = 2'h0;
      end else if (sel_hit(host_sel, sel_code1)) begin
         hit = 2'h1;
      end else if (sel_hit(host_sel, sel_code2)) begin
         hit = 2'h2;
      end else begin
         hit = 2'h0;
         any_hit = 1'b0;
      end
   end

   // Lane masks per step; in 18-bit mode the third code selects nothing
   always_comb begin
      rd_mask_nxt = M_NONE;
      ld_mask_nxt = M_NONE;
      unique case (host_kind)
         WLTM_HOST12: begin
            unique case (hit)
               2'h0: begin
                  rd_mask_nxt = M_FIRST12;
                  ld_mask_nxt = M_FIRST12;
               end
               2'h1: begin
                  rd_mask_nxt = M_MID12;
                  ld_mask_nxt = M_MID12;
               end
               2'h2: begin
                  rd_mask_nxt = M_LAST12;
                  ld_mask_nxt = M_LAST12;
               end
               default: begin
                  rd_mask_nxt = M_NONE;
                  ld_mask_nxt = M_NONE;
               end
            endcase
         end
         WLTM_HOST18: begin
            if (hit == 2'h0) begin
               rd_mask_nxt = M_FIRST18;
               ld_mask_nxt = M_FIRST18;
            end else if (hit == 2'h1) begin
               rd_mask_nxt = M_LAST18;
               ld_mask_nxt = M_LAST18;
            end
         end
      endcase
   end

   assign rd_busy = (rd_cnt_r != '0);
   // Reads only when a word is held and no strobe runs
   assign rd_go = host_rd && any_hit && ob_full_r && !rd_busy && (rd_mask_nxt != M_NONE);
   // Loads refused while a complete word waits for the wide side
   assign ld_go = host_ld && any_hit && !ib_full_r && (ld_mask_nxt != M_NONE);

   // Outbound holding word and its full flag
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ob_full_r <= 1'b0;
         outbound_buffer_r <= '0;
      end else if (!ob_full_r && buf_out_if.valid) begin
         outbound_buffer_r <= buf_out_if.data;
         ob_full_r <= 1'b1;
      end else if (rd_go && rd_mask_nxt[LANE3]) begin
         ob_full_r <= 1'b0;
      end
   end

   // Read strobe timer sized to the host kind
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_cnt_r <= '0;
         rd_mask_r <= M_NONE;
      end else if (rd_go) begin
         rd_mask_r <= rd_mask_nxt;
         // Long strobe keeps data up for the slower host
         rd_cnt_r <= host18_mode ? CNT_W'(LONG_PULSE_CYC) : CNT_W'(SHORT_PULSE_CYC);
      end else if (rd_busy) begin
         rd_cnt_r <= rd_cnt_r - CNT_W'(1);
         if (rd_cnt_r == CNT_W'(1)) begin
            rd_mask_r <= M_NONE;
         end
      end
   end

   // Read data captured at strobe start; the buffer may refill meanwhile
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else if (rd_go) begin
         rdata_r <= lane_mux(outbound_buffer_r, rd_mask_nxt, host18_mode);
      end else if (rd_busy && rd_cnt_r == CNT_W'(1)) begin
         rdata_r <= '0;
      end
   end

   // Inbound lane capture from the host bus
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inbound_buffer_r <= '0;
      end else if (ld_go) begin
         if (host18_mode) begin
            if (ld_mask_nxt[LANE0]) inbound_buffer_r[L2_LO-1:L0_LO] <= host_wdata;
            if (ld_mask_nxt[LANE3]) inbound_buffer_r[WORD_W-1:L2_LO] <= host_wdata;
         end else begin
            if (ld_mask_nxt[LANE0]) inbound_buffer_r[L1_LO-1:L0_LO] <= host_wdata[11:0];
            if (ld_mask_nxt[LANE1]) inbound_buffer_r[L3_LO-1:L1_LO] <= host_wdata[11:0];
            if (ld_mask_nxt[LANE3]) inbound_buffer_r[WORD_W-1:L3_LO] <= host_wdata[11:0];
         end
      end
   end

   // Inbound full flag; loads are refused while set so set and clear never meet
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ib_full_r <= 1'b0;
      end else if (ld_go && ld_mask_nxt[LANE3]) begin
         ib_full_r <= 1'b1;
      end else if (ib_full_r && ib_ready) begin
         ib_full_r <= 1'b0;
      end
   end

   // One-cycle load strobe copy for observation
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ld_mask_r <= M_NONE;
      end else begin
         ld_mask_r <= ld_go ? ld_mask_nxt : M_NONE;
      end
   end

   assign host_rdata = rdata_r;
   assign host_rdata_en = rd_busy;
   assign lane_rd_strobe = rd_mask_r;
   assign lane_ld_strobe = ld_mask_r;
   assign ob_full = ob_full_r;
   assign ob_empty = !ob_full_r;
   assign ib_valid = ib_full_r;
   assign ib_data = inbound_buffer_r;
endmodule // wltm_mixer
`default_nettype wire

//--- tb/wltm_host_model.sv
// Purpose: Host processor model issuing read and load pulses.
// Assumes: One request at a time; the caller waits out each read window.
// Notes: Released lines show the inverse of the last value, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module wltm_host_model (
   input wire logic clk,
   output logic [wltm_pkg::SEL_W-1:0] host_sel,
   output logic host_rd,
   output logic host_ld,
   output logic [wltm_pkg::HOST_W-1:0] host_wdata
);
   import wltm_pkg::*;
   // Idle bus at time zero
   initial begin
      host_sel = 6'h00;
      host_rd = 1'b0;
      host_ld = 1'b0;
      host_wdata = 18'h00000;
   end
   // One read pulse; the answer is visible just after the taking edge
   task automatic rd(input logic [SEL_W-1:0] s);
      @(posedge clk);
      host_rd <= 1'b1;
      host_sel <= s;
      @(posedge clk);
      host_rd <= 1'b0;
      host_sel <= ~s;
      #1;
   endtask
   // One load pulse with its data word
   task automatic ld(input logic [SEL_W-1:0] s, input logic [HOST_W-1:0] w);
      @(posedge clk);
      host_ld <= 1'b1;
      host_sel <= s;
      host_wdata <= w;
      @(posedge clk);
      host_ld <= 1'b0;
      host_sel <= ~s;
      host_wdata <= ~w;
      #1;
   endtask
endmodule // wltm_host_model
`default_nettype wire

//--- tb/wltm_mixer_checker.sv
// Purpose: Port-level checks for the word lane transfer mixer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Read window length is counted by helper logic.
`timescale 1ns/1ps
`default_nettype none
module wltm_mixer_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic host18_mode,
   input wire logic [wltm_pkg::SEL_W-1:0] sel_code0,
   input wire logic [wltm_pkg::SEL_W-1:0] sel_code1,
   input wire logic [wltm_pkg::SEL_W-1:0] sel_code2,
   input wire logic [wltm_pkg::SEL_W-1:0] host_sel,
   input wire logic host_rd,
   input wire logic host_ld,
   input wire logic [wltm_pkg::HOST_W-1:0] host_rdata,
   input wire logic host_rdata_en,
   input wire logic [3:0] lane_rd_strobe,
   input wire logic [3:0] lane_ld_strobe,
   input wire logic ob_full,
   input wire logic ob_empty,
   input wire logic ib_valid
);
   import wltm_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic hit0, hit1, hit2, rd_ok; // Code hits, code0 wins on overlap
   logic [7:0] en_cnt_r; // High cycles of the current read window
   assign hit0 = host_sel == sel_code0;
   assign hit1 = host_sel == sel_code1 && !hit0;
   assign hit2 = host_sel == sel_code2 && !hit0 && !hit1;
   assign rd_ok = host_rd && ob_full && !host_rdata_en;
   // Window counter, cleared between windows
   always_ff @(posedge clk) begin
      if (sys_rst || !host_rdata_en) en_cnt_r <= 8'h00;
      else en_cnt_r <= en_cnt_r + 8'h01;
   end
   property p_width;
      $fell(host_rdata_en) |-> en_cnt_r == (host18_mode ? LONG_PULSE_CYC : SHORT_PULSE_CYC);
   endproperty
   a_width: assert property (p_width) else $error("read window length wrong");
   property p_first;
      rd_ok && hit0 |=> host_rdata_en && lane_rd_strobe == (host18_mode ? M_FIRST18 : M_FIRST12);
   endproperty
   a_first: assert property (p_first) else $error("first lane strobe wrong");
   property p_mid;
      rd_ok && hit1 && !host18_mode |=> lane_rd_strobe == M_MID12;
   endproperty
   a_mid: assert property (p_mid) else $error("middle strobe wrong");
   property p_last;
      rd_ok && (host18_mode ? hit1 : hit2) |=>
         !ob_full && lane_rd_strobe == (host18_mode ? M_LAST18 : M_LAST12);
   endproperty
   a_last: assert property (p_last) else $error("last lane read wrong");
   property p_refuse;
      host_rd && !host_rdata_en && !(hit0 || hit1 || hit2) |=> !host_rdata_en;
   endproperty
   a_refuse: assert property (p_refuse) else $error("foreign code answered");
   property p_hold;
      $rose(host_rdata_en) |=> $stable(host_rdata) [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("read data not held");
   property p_strobe_en;
      (lane_rd_strobe != M_NONE) == host_rdata_en;
   endproperty
   a_strobe_en: assert property (p_strobe_en) else $error("strobe and enable differ");
   property p_ld_last;
      host_ld && !ib_valid && (host18_mode ? hit1 : hit2) |=>
         ib_valid && lane_ld_strobe == (host18_mode ? M_LAST18 : M_LAST12);
   endproperty
   a_ld_last: assert property (p_ld_last) else $error("last load did not fill");
   property p_ld_full;
      host_ld && ib_valid |=> lane_ld_strobe == M_NONE;
   endproperty
   a_ld_full: assert property (p_ld_full) else $error("load taken while full");
   property p_empty;
      ob_empty == !ob_full;
   endproperty
   a_empty: assert property (p_empty) else $error("empty flag not inverse of full");
endmodule // wltm_mixer_checker
bind wltm_mixer wltm_mixer_checker i_chk (.clk(clk), .sys_rst(sys_rst),
   .host18_mode(host18_mode), .sel_code0(sel_code0), .sel_code1(sel_code1),
   .sel_code2(sel_code2), .host_sel(host_sel), .host_rd(host_rd), .host_ld(host_ld),
   .host_rdata(host_rdata), .host_rdata_en(host_rdata_en),
   .lane_rd_strobe(lane_rd_strobe), .lane_ld_strobe(lane_ld_strobe),
   .ob_full(ob_full), .ob_empty(ob_empty), .ib_valid(ib_valid));
`default_nettype wire

//--- tb/tb_word_lane_transfer_mixer.sv
// Purpose: Self-checking bench for the word lane transfer mixer.
// Assumes: Host model drives the host bus; checker is bound to the mixer.
// Notes: Mode and codes change only under reset, since they are static.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
   begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module tb_word_lane_transfer_mixer;
   import wltm_pkg::*;
   logic clk, sys_rst, h18, ob_valid, ob_ready, ob_full, ob_empty;
   logic ib_valid, ib_ready, rd, ld, en;
   logic [SEL_W-1:0] c0, c1, c2, sel;
   logic [HOST_W-1:0] wd, rdata;
   logic [3:0] rs, ls;
   logic [WORD_W-1:0] ob_data, ib_data;
   int mismatches, total_checks, cyc;
   wltm_mixer i_dut (.clk(clk), .sys_rst(sys_rst), .host18_mode(h18),
      .sel_code0(c0), .sel_code1(c1), .sel_code2(c2), .host_sel(sel), .host_rd(rd),
      .host_ld(ld), .host_wdata(wd), .host_rdata(rdata), .host_rdata_en(en),
      .lane_rd_strobe(rs), .lane_ld_strobe(ls), .ob_valid(ob_valid), .ob_data(ob_data),
      .ob_ready(ob_ready), .ob_full(ob_full), .ob_empty(ob_empty), .ib_valid(ib_valid),
      .ib_data(ib_data), .ib_ready(ib_ready));
   wltm_host_model i_host (.clk(clk), .host_sel(sel), .host_rd(rd), .host_ld(ld),
      .host_wdata(wd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Cut a hang short; the whole run needs under 2000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic do_reset(input logic m, input logic [SEL_W-1:0] a, b, c);
      @(posedge clk);
      sys_rst <= 1'b1;
      h18 <= m;
      c0 <= a;
      c1 <= b;
      c2 <= c;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   // Offer a word and hold it until the edge that takes it
   task automatic push(input logic [WORD_W-1:0] w);
      int k;
      ob_valid <= 1'b1;
      ob_data <= w;
      k = 0;
      #1;
      // Ready is judged once settled, never in the time step of the taking edge
      while (ob_ready !== 1'b1 && k < 300) begin
         @(posedge clk);
         #1;
         k++;
      end
      @(posedge clk);
      `CHK("push_taken", 1'b1, k < 300);
   endtask
   // Read one step, then measure how long the data window stands
   task automatic rdc(input logic [SEL_W-1:0] s, input logic [HOST_W-1:0] e,
                      input logic [3:0] st);
      int n;
      i_host.rd(s);
      `CHK("rdata", e, rdata & (h18 ? 18'h3ffff : 18'h00fff));
      `CHK("strobe", st, rs);
      n = 0;
      while (en === 1'b1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("width", h18 ? LONG_PULSE_CYC : SHORT_PULSE_CYC, n);
   endtask
   task automatic drain();
      @(posedge clk);
      ib_ready <= 1'b1;
      @(posedge clk);
      ib_ready <= 1'b0;
      #1;
      `CHK("ib_drained", 1'b0, ib_valid);
   endtask
   task automatic t_out12();
      do_reset(1'b0, SEL_CODE0_DEF, SEL_CODE1_DEF, SEL_CODE2_DEF);
      push(36'h123456789);
      ob_valid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("full", 1'b1, ob_full);
      i_host.rd(6'h3b);
      `CHK("bad_code", 1'b0, en);
      i_host.rd(6'h07); // Code 70 with its digit order turned round
      `CHK("bit_order", 1'b0, en);
      rdc(SEL_CODE0_DEF, 18'h00789, 4'h1);
      rdc(SEL_CODE1_DEF, 18'h00456, 4'h6);
      rdc(SEL_CODE2_DEF, 18'h00123, 4'h8);
      `CHK("empty", 1'b1, ob_empty);
   endtask
   task automatic t_in12();
      i_host.ld(SEL_CODE0_DEF, 18'h3fabc);
      `CHK("ld0", 4'h1, ls);
      i_host.ld(SEL_CODE1_DEF, 18'h3fdef);
      `CHK("ld1", 4'h6, ls);
      i_host.ld(SEL_CODE2_DEF, 18'h3f321);
      `CHK("ib_full", 1'b1, ib_valid);
      i_host.ld(SEL_CODE0_DEF, 18'h00555);
      `CHK("ld_refused", 4'h0, ls);
      `CHK("ib12", 36'h321defabc, ib_data);
      drain();
   endtask
   task automatic t_out18();
      logic [WORD_W-1:0] w [3];
      w = '{36'h9abcdef01, 36'h2468ace13, 36'h13579bdf5};
      do_reset(1'b1, 6'h11, 6'h12, 6'h13);
      for (int i = 0; i < 3; i++) push(w[i]);
      ob_valid <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      `CHK("refused", 1'b0, ob_ready);
      i_host.rd(6'h13);
      `CHK("code2_idle", 1'b0, en);
      for (int i = 0; i < 3; i++) begin
         rdc(6'h11, w[i][17:0], 4'h3);
         rdc(6'h12, w[i][35:18], 4'hc);
         `CHK("ready", 1'b1, ob_ready);
      end
      `CHK("drained", 1'b1, ob_empty);
   endtask
   task automatic t_in18();
      i_host.ld(6'h11, 18'h2abcd);
      `CHK("ld0_18", 4'h3, ls);
      i_host.ld(6'h12, 18'h15432);
      `CHK("ld1_18", 4'hc, ls);
      `CHK("ib18", 36'h550caabcd, ib_data);
      drain();
   endtask
   initial begin
      sys_rst = 1'b1;
      h18 = 1'b0;
      c0 = SEL_CODE0_DEF;
      c1 = SEL_CODE1_DEF;
      c2 = SEL_CODE2_DEF;
      ob_valid = 1'b0;
      ob_data = 36'h000000000;
      ib_ready = 1'b0;
      t_out12();
      t_in12();
      t_out18();
      t_in18();
      finish_test();
   end
endmodule // tb_word_lane_transfer_mixer
`default_nettype wire
